/* sec_chk.sv */
// checker: port-level assertions for the erase and freeze block
`timescale 1ns/10ps
`default_nettype none
module sec_chk #(
	parameter int MEDIA_WORDS = 4096
) (
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// media port
	input wire sec_pkg::sec_media_t media,
	input wire logic media_fail,
	input wire logic media_fault,
	// state
	input wire logic locked,
	input wire logic frozen,
	input wire logic unit_number
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// bus answers in the access phase and never errors
	a_apb_answer: assert property (psel && !penable |=> pready)
		else $error("no ready in access phase");
	a_no_slverr: assert property (pready |-> !pslverr)
		else $error("slave error raised");
	// frozen state is sticky and blocks lock changes and erasing
	a_frozen_holds: assert property (frozen |=> frozen)
		else $error("frozen state cleared without reset");
	a_frozen_no_wr: assert property (frozen |-> !media.wr)
		else $error("media written while frozen");
	a_unlock_cause: assert property ($fell(locked) |-> !frozen)
		else $error("unlock while frozen");
	a_lock_frozen: assert property ($rose(locked) |-> !frozen)
		else $error("lock state changed while frozen");
	// erase writes stay in range with one fixed pattern
	a_wr_range: assert property (media.wr |-> media.addr < MEDIA_WORDS)
		else $error("erase address out of range");
	a_wr_data: assert property (media.wr |-> media.data == 16'h0000 ||
		media.data == sec_pkg::ENH_PATTERN)
		else $error("erase data is not a known pattern");
	a_mode_fixed: assert property (media.wr && $past(media.wr) |->
		$stable(media.data))
		else $error("erase pattern changed mid erase");
endmodule : sec_chk
bind sec_erase_freeze sec_chk #(.MEDIA_WORDS(MEDIA_WORDS)) i_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .media(media),
	.media_fail(media_fail), .media_fault(media_fault), .locked(locked),
	.frozen(frozen), .unit_number(unit_number));
`default_nettype wire

/* sec_erase_freeze.sv */
// security erase prepare, erase unit and freeze command interpreter
//
// Notes on behaviour
// RULE1: host sends prepare directly before erase unit
// RULE2: erase unit takes exactly one data sector
// RULE3: abort erase: unsupported, frozen, unarmed, overwrite fail
// RULE4: abort erase when password compare mismatches
// RULE5: normal erase writes zeros everywhere
// RULE6: enhanced erase writes pattern, incl. retired sectors
// RULE7: word0 bit0 selects user/master, words 1-16 password
// RULE8: word0 bit1 selects normal or enhanced mode
// RULE9: successful erase unlocks, master password kept
// RULE10: good completion: ready only, others clear
// RULE11: error completion: ready, failure, fault on fault
// RULE12: abort when action cannot complete otherwise
// RULE13: unit select bit echoes selected device
// RULE14: host issues commands only while ready
// RULE15: freeze command enters frozen state
// RULE16: frozen rejects all lock-altering commands
// RULE17: only reset leaves frozen state
// RULE18: freeze while frozen completes, stays frozen
// RULE19: abort freeze when unsupported or locked
// RULE20: abort prepare when unsupported or frozen
// RULE21: armed flag set by prepare, cleared otherwise
`timescale 1ns/10ps
`default_nettype none
module sec_erase_freeze #(
	parameter int MEDIA_WORDS = 4096
) (
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// media write port and its result
	output sec_pkg::sec_media_t media,
	input wire logic media_fail,
	input wire logic media_fault,
	// lock state and device number
	output logic locked,
	output logic frozen,
	input wire logic unit_number
);
	sec_pkg::sec_state_t state;
	sec_pkg::sec_status_t status;
	logic [7:0] error_register;
	logic [7:0] sector_count_register;
	logic [7:0] sector_number_register;
	logic [7:0] cylinder_low_register;
	logic [7:0] cylinder_high_register;
	logic [7:0] drive_select_register;
	logic [7:0] features_register;
	logic [7:0] control;
	logic [7:0] word_idx;
	logic [15:0] ctrl_word;
	logic pw_ok;
	logic armed;
	logic [15:0] user_pw [16];
	logic [15:0] master_pw [16];
	logic [15:0] erase_addr;
	logic erase_bad;
	logic erase_fault;
	logic wr_en;
	logic rd_en;
	logic cmd_wr;
	logic data_wr;
	logic [7:0] cmd;
	logic selected;
	logic feat_ok;

	// control bit0 enables the security feature set
	assign feat_ok = control[0];
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & penable & ~pwrite;
	assign cmd = pwdata[7:0];
	// RULE13: unit select match
	assign selected = drive_select_register[sec_pkg::UNIT_SELECT_BIT] ==
		unit_number;
	// RULE14: refuse command while busy
	assign cmd_wr = wr_en & (paddr == sec_pkg::ADDR_COMMAND) & selected &
		status.unit_ready_flag & ~status.busy_flag;
	assign data_wr = wr_en & (paddr == sec_pkg::ADDR_DATA) &
		(state == sec_pkg::ST_DATA);

	// function: map an offset onto a password slot
	function automatic logic pw_hit(input logic [7:0] a,
		input logic [7:0] base);
		pw_hit = (a >= base) && (a < base + 8'h40) && (a[1:0] == 2'b00);
	endfunction : pw_hit

	// zero-wait apb answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
		end
	end

	// read mux, registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel & ~penable & ~pwrite) begin
			unique case (paddr)
				sec_pkg::ADDR_ERROR: prdata <= {24'h000000, error_register};
				sec_pkg::ADDR_SECTOR_COUNT:
					prdata <= {24'h000000, sector_count_register};
				sec_pkg::ADDR_SECTOR_NUMBER:
					prdata <= {24'h000000, sector_number_register};
				sec_pkg::ADDR_CYLINDER_LOW:
					prdata <= {24'h000000, cylinder_low_register};
				sec_pkg::ADDR_CYLINDER_HIGH:
					prdata <= {24'h000000, cylinder_high_register};
				sec_pkg::ADDR_DRIVE_SELECT:
					prdata <= {24'h000000, drive_select_register};
				sec_pkg::ADDR_STATUS: prdata <= {24'h000000, status};
				sec_pkg::ADDR_CONTROL:
					prdata <= {22'h000000, frozen, locked, control};
				default: prdata <= 32'h00000000;
			endcase
		end
	end

	// task-file input registers, host written
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sector_count_register <= 8'h00;
			sector_number_register <= 8'h00;
			cylinder_low_register <= 8'h00;
			cylinder_high_register <= 8'h00;
			drive_select_register <= sec_pkg::DRIVE_SELECT_RESET;
			features_register <= 8'h00;
			control <= sec_pkg::CONTROL_RESET;
		end else if (wr_en & ~status.busy_flag) begin
			unique case (paddr)
				sec_pkg::ADDR_SECTOR_COUNT: sector_count_register <= cmd;
				sec_pkg::ADDR_SECTOR_NUMBER: sector_number_register <= cmd;
				sec_pkg::ADDR_CYLINDER_LOW: cylinder_low_register <= cmd;
				sec_pkg::ADDR_CYLINDER_HIGH: cylinder_high_register <= cmd;
				sec_pkg::ADDR_DRIVE_SELECT: drive_select_register <= cmd;
				sec_pkg::ADDR_FEATURES: features_register <= cmd;
				sec_pkg::ADDR_CONTROL: control <= cmd;
				default: ;
			endcase
		end
	end

	// stored passwords, loaded by software while not frozen
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 16; i++) begin
				user_pw[i] <= 16'h0000;
				master_pw[i] <= 16'h0000;
			end
		end else if (wr_en & ~frozen) begin
			if (pw_hit(paddr, sec_pkg::ADDR_USER_PW))
				user_pw[paddr[5:2]] <= pwdata[15:0];
			if (pw_hit(paddr, sec_pkg::ADDR_MASTER_PW))
				master_pw[paddr[5:2]] <= pwdata[15:0];
		end
	end

	// RULE2: count sector words and compare password
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			word_idx <= 8'h00;
			ctrl_word <= 16'h0000;
			pw_ok <= 1'b1;
		end else if (cmd_wr) begin
			word_idx <= 8'h00;
			pw_ok <= 1'b1;
		end else if (data_wr) begin
			word_idx <= word_idx + 8'h01;
			if (word_idx == 8'h00)
				ctrl_word <= pwdata[15:0];
			// RULE7: compare selected password words
			if (word_idx >= sec_pkg::PW_FIRST_WORD &&
				word_idx <= sec_pkg::PW_LAST_WORD) begin
				if (pwdata[15:0] != (ctrl_word[sec_pkg::CW_IDENT_BIT] ?
					master_pw[word_idx[3:0] - 4'h1] :
					user_pw[word_idx[3:0] - 4'h1]))
					pw_ok <= 1'b0;
			end
		end
	end

	// RULE21: armed by prepare, cleared by any other command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			armed <= 1'b0;
		else if (cmd_wr)
			armed <= (cmd == sec_pkg::CMD_ERASE_PREPARE) & feat_ok & ~frozen;
	end

	// RULE17: frozen clears only by reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			frozen <= 1'b0;
		// RULE15: freeze completes into frozen
		// RULE18: freeze while frozen keeps frozen
		else if (cmd_wr && cmd == sec_pkg::CMD_FREEZE && feat_ok && !locked)
			frozen <= 1'b1;
	end

	// lock state, erase success clears it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			locked <= 1'b0;
		else if (wr_en && paddr == sec_pkg::ADDR_CONTROL && !frozen)
			locked <= pwdata[8];
		// RULE9: unlock on successful erase, master kept
		else if (state == sec_pkg::ST_DONE && error_register == 8'h00 &&
			!erase_fault && armed == 1'b0 && erase_addr != 16'h0)
			locked <= 1'b0;
	end

	// overwrite sequencer and media port
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			erase_addr <= 16'h0000;
			erase_bad <= 1'b0;
			erase_fault <= 1'b0;
			media <= '0;
		end else if (state == sec_pkg::ST_ERASE) begin
			media.wr <= 1'b1;
			media.addr <= erase_addr;
			// RULE5: normal mode writes zeros
			// RULE6: enhanced mode writes pattern over all areas
			// RULE8: control word bit1 picks the mode
			media.data <= ctrl_word[sec_pkg::CW_MODE_BIT] ?
				sec_pkg::ENH_PATTERN : 16'h0000;
			erase_addr <= erase_addr + 16'h0001;
			// RULE3: overwrite failure recorded
			if (media_fail)
				erase_bad <= 1'b1;
			if (media_fault)
				erase_fault <= 1'b1;
		end else begin
			media.wr <= 1'b0;
			// a new command must not inherit an old fault record
			if (state == sec_pkg::ST_CHECK || cmd_wr) begin
				erase_addr <= 16'h0000;
				erase_bad <= 1'b0;
				erase_fault <= 1'b0;
			end
		end
	end

	// command state machine with status and error outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= sec_pkg::ST_IDLE;
			status <= 8'h40;
			error_register <= 8'h00;
		end else begin
			unique case (state)
				sec_pkg::ST_IDLE: begin
					if (cmd_wr) begin
						error_register <= 8'h00;
						status <= 8'h80;
						state <= sec_pkg::ST_DONE;
						unique case (cmd)
							sec_pkg::CMD_ERASE_UNIT: begin
								// RULE3: abort when unarmed, frozen, unsupported
								// RULE16: frozen rejects erase unit
								if (!feat_ok || frozen || !armed)
									error_register[sec_pkg::ERR_ABORT_BIT] <= 1'b1;
								else begin
									status <= 8'h88;
									state <= sec_pkg::ST_DATA;
								end
							end
							// RULE20: prepare aborts if unsupported or frozen
							sec_pkg::CMD_ERASE_PREPARE:
								error_register[sec_pkg::ERR_ABORT_BIT] <=
									!feat_ok || frozen;
							// RULE19: freeze aborts when locked
							sec_pkg::CMD_FREEZE:
								error_register[sec_pkg::ERR_ABORT_BIT] <=
									!feat_ok || locked;
							// RULE16: other lock commands refused when frozen
							// RULE12: other actions not completed here
							default:
								error_register[sec_pkg::ERR_ABORT_BIT] <= 1'b1;
						endcase
					end
				end
				sec_pkg::ST_DATA: begin
					if (data_wr && word_idx == sec_pkg::SECTOR_WORDS) begin
						status <= 8'h80;
						state <= sec_pkg::ST_CHECK;
					end
				end
				sec_pkg::ST_CHECK: begin
					// RULE4: mismatch aborts
					if (!pw_ok) begin
						error_register[sec_pkg::ERR_ABORT_BIT] <= 1'b1;
						state <= sec_pkg::ST_DONE;
					end else
						state <= sec_pkg::ST_ERASE;
				end
				sec_pkg::ST_ERASE: begin
					if (erase_addr == 16'(MEDIA_WORDS - 1)) begin
						state <= sec_pkg::ST_DONE;
						if (erase_bad || media_fail)
							error_register[sec_pkg::ERR_ABORT_BIT] <= 1'b1;
					end
				end
				sec_pkg::ST_DONE: begin
					// RULE10: clean completion shows ready only
					// RULE11: error completion sets failure, fault only when erase_fault is set
					status <= {1'b0, 1'b1, erase_fault, 4'h0,
						error_register != 8'h00};
					state <= sec_pkg::ST_IDLE;
				end
				default: state <= sec_pkg::ST_IDLE;
			endcase
		end
	end
endmodule : sec_erase_freeze
`default_nettype wire

/* sec_media_model.sv */
// partner: storage media that counts erase writes and reports failures
`timescale 1ns/10ps
`default_nettype none
module sec_media_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// write port from the block
	input wire sec_pkg::sec_media_t media,
	// scenario controls
	input wire logic fail_en,
	input wire logic fault_en,
	input wire logic clr,
	input wire logic [15:0] exp_data,
	// answers
	output logic media_fail,
	output logic media_fault,
	output logic [15:0] wr_cnt,
	output logic [15:0] bad_cnt
);
	// count writes, flag failures once writing starts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_cnt <= 16'h0000;
			bad_cnt <= 16'h0000;
			media_fail <= 1'b0;
			media_fault <= 1'b0;
		end else if (clr) begin
			wr_cnt <= 16'h0000;
			bad_cnt <= 16'h0000;
			media_fail <= 1'b0;
			media_fault <= 1'b0;
		end else if (media.wr) begin
			wr_cnt <= wr_cnt + 16'h0001;
			if (media.data !== exp_data)
				bad_cnt <= bad_cnt + 16'h0001;
			if (fail_en)
				media_fail <= 1'b1;
			if (fault_en)
				media_fault <= 1'b1;
		end
	end
endmodule : sec_media_model
`default_nettype wire

/* sec_pkg.sv */
// package: register map, codes, field positions and types for the erase block
`default_nettype none
package sec_pkg;
	// apb register byte offsets
	localparam logic [7:0] ADDR_ERROR = 8'h04;
	localparam logic [7:0] ADDR_SECTOR_COUNT = 8'h08;
	localparam logic [7:0] ADDR_SECTOR_NUMBER = 8'h0C;
	localparam logic [7:0] ADDR_CYLINDER_LOW = 8'h10;
	localparam logic [7:0] ADDR_CYLINDER_HIGH = 8'h14;
	localparam logic [7:0] ADDR_DRIVE_SELECT = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1C;
	localparam logic [7:0] ADDR_FEATURES = 8'h20;
	localparam logic [7:0] ADDR_COMMAND = 8'h24;
	localparam logic [7:0] ADDR_DATA = 8'h00;
	localparam logic [7:0] ADDR_CONTROL = 8'h28;
	localparam logic [7:0] ADDR_USER_PW = 8'h40;
	localparam logic [7:0] ADDR_MASTER_PW = 8'h80;
	// command codes
	localparam logic [7:0] CMD_SET_PASSWORD = 8'hF1;
	localparam logic [7:0] CMD_UNLOCK = 8'hF2;
	localparam logic [7:0] CMD_ERASE_PREPARE = 8'hF3;
	localparam logic [7:0] CMD_ERASE_UNIT = 8'hF4;
	localparam logic [7:0] CMD_FREEZE = 8'hF5;
	localparam logic [7:0] CMD_DISABLE_PASSWORD = 8'hF6;
	// field positions
	localparam int ERR_ABORT_BIT = 2;
	localparam int UNIT_SELECT_BIT = 4;
	localparam int CW_IDENT_BIT = 0;
	localparam int CW_MODE_BIT = 1;
	// sector layout in 16-bit words
	localparam logic [7:0] SECTOR_WORDS = 8'hFF;
	localparam logic [7:0] PW_FIRST_WORD = 8'h01;
	localparam logic [7:0] PW_LAST_WORD = 8'h10;
	// reset values
	localparam logic [7:0] DRIVE_SELECT_RESET = 8'hA0;
	localparam logic [7:0] CONTROL_RESET = 8'h01;
	// pattern written by enhanced erase, arbitrary
	localparam logic [15:0] ENH_PATTERN = 16'hA5A5;
	// status flags carried together
	typedef struct packed {
		logic busy_flag;
		logic unit_ready_flag;
		logic device_fault_flag;
		logic na4;
		logic transfer_request_flag;
		logic na2;
		logic na1;
		logic failure_flag;
	} sec_status_t;
	// media write port signals
	typedef struct packed {
		logic wr;
		logic [15:0] addr;
		logic [15:0] data;
	} sec_media_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DATA = 3'b001,
		ST_CHECK = 3'b010,
		ST_ERASE = 3'b011,
		ST_DONE = 3'b100
	} sec_state_t;
endpackage : sec_pkg
`default_nettype wire

/* testbench.sv */
// testbench: apb-driven scenarios for erase, freeze and lock handling
`timescale 1ns/10ps
`default_nettype none
module testbench;
	localparam int MW = 16;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, media_fail, media_fault, locked, frozen;
	logic unit_number = 1, fail_en = 0, fault_en = 0, clr = 0;
	logic [15:0] exp_data = 16'h0000, wr_cnt, bad_cnt;
	sec_pkg::sec_media_t media;
	int num_errors = 0, checks_done = 0;
	logic [31:0] rv;
	sec_erase_freeze #(.MEDIA_WORDS(MW)) i_dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .media(media), .media_fail(media_fail),
		.media_fault(media_fault), .locked(locked), .frozen(frozen),
		.unit_number(unit_number));
	sec_media_model i_med (.pclk(pclk), .presetn(presetn), .media(media),
		.fail_en(fail_en), .fault_en(fault_en), .clr(clr),
		.exp_data(exp_data), .media_fail(media_fail),
		.media_fault(media_fault), .wr_cnt(wr_cnt), .bad_cnt(bad_cnt));
	// clock
	initial begin
		forever #10 pclk = ~pclk;
	end
	task automatic chk(input string n, input logic [31:0] s, e);
		checks_done++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// one apb transfer, held until pready is sampled high
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rv = prdata;
		psel <= 0; penable <= 0;
	endtask : xfer
	task automatic cmd(input logic [7:0] c);
		xfer(1, sec_pkg::ADDR_DRIVE_SELECT, 32'hB0);
		xfer(1, sec_pkg::ADDR_COMMAND, {24'h0, c});
		// poll until no longer busy, or until data is requested, before the next command
		do xfer(0, sec_pkg::ADDR_STATUS, 0); while (rv[7] && !rv[3]);
	endtask : cmd
	// prepare, erase unit, one sector; rv holds final status
	task automatic erase(input logic [1:0] cw, input logic [15:0] pw);
		// prepare sent directly before erase unit
		cmd(sec_pkg::CMD_ERASE_PREPARE);
		cmd(sec_pkg::CMD_ERASE_UNIT);
		chk("drq status", rv, 32'h88);
		for (int i = 0; i < 256; i++)
			xfer(1, sec_pkg::ADDR_DATA, i == 0 ? cw : (i < 17 ? pw + i : 0));
		do xfer(0, sec_pkg::ADDR_STATUS, 0); while (rv[7]);
	endtask : erase
	task automatic aborted(input logic [7:0] st);
		chk("status", rv, st);
		xfer(0, sec_pkg::ADDR_ERROR, 0);
		chk("error", rv, 32'h04);
	endtask : aborted
	task automatic t_reset;
		xfer(0, sec_pkg::ADDR_STATUS, 0);
		chk("status", rv, 32'h40);
		xfer(0, sec_pkg::ADDR_DRIVE_SELECT, 0);
		chk("drive select", rv, 32'hA0);
		xfer(0, 8'h3C, 0);
		chk("unmapped", rv, 32'h0);
		for (int i = 0; i < 16; i++) begin
			xfer(1, sec_pkg::ADDR_USER_PW + 4 * i, 32'h1001 + i);
			xfer(1, sec_pkg::ADDR_MASTER_PW + 4 * i, 32'h2001 + i);
		end
	endtask : t_reset
	task automatic t_no_prepare;
		cmd(sec_pkg::CMD_ERASE_UNIT);
		aborted(8'h41);
		xfer(1, sec_pkg::ADDR_CONTROL, 32'h101);
		xfer(0, sec_pkg::ADDR_CONTROL, 0);
		chk("control", rv, 32'h101);
		chk("locked", locked, 1);
	endtask : t_no_prepare
	task automatic t_bad_pw;
		clr <= 1; @(posedge pclk); clr <= 0;
		erase(2'b00, 16'h3000);
		aborted(8'h41);
		chk("no writes", wr_cnt, 0);
		cmd(sec_pkg::CMD_FREEZE);
		aborted(8'h41);
		chk("frozen", frozen, 0);
	endtask : t_bad_pw
	task automatic t_erase_ok(input logic [1:0] cw, input logic [15:0] pw, pat);
		xfer(1, sec_pkg::ADDR_CONTROL, 32'h101);
		exp_data <= pat; clr <= 1; @(posedge pclk); clr <= 0;
		erase(cw, pw);
		chk("status", rv, 32'h40);
		chk("locked", locked, 0);
		chk("writes", wr_cnt, MW);
		chk("pattern", bad_cnt, 0);
		xfer(0, sec_pkg::ADDR_DRIVE_SELECT, 0);
		chk("drive select", rv, 32'hB0);
	endtask : t_erase_ok
	task automatic t_media_err;
		for (int i = 0; i < 2; i++) begin
			fail_en <= 1; fault_en <= (i == 1); clr <= 1; @(posedge pclk); clr <= 0;
			erase(2'b00, 16'h1000);
			aborted(i ? 8'h61 : 8'h41);
		end
		fail_en <= 0; fault_en <= 0;
	endtask : t_media_err
	task automatic t_unit_sel;
		unit_number <= 0;
		cmd(sec_pkg::CMD_FREEZE);
		chk("other unit", frozen, 0);
		unit_number <= 1;
		xfer(1, sec_pkg::ADDR_CONTROL, 32'h0);
		cmd(sec_pkg::CMD_FREEZE);
		aborted(8'h41);
		chk("unsupported frozen", frozen, 0);
		xfer(1, sec_pkg::ADDR_CONTROL, 32'h1);
	endtask : t_unit_sel
	task automatic t_frozen;
		logic [7:0] c [5] = '{8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF6};
		for (int i = 0; i < 2; i++) begin
			cmd(sec_pkg::CMD_FREEZE);
			chk("freeze status", rv, 32'h40);
			chk("frozen", frozen, 1);
		end
		foreach (c[i]) begin
			cmd(c[i]);
			aborted(8'h41);
		end
		xfer(1, sec_pkg::ADDR_CONTROL, 32'h101);
		xfer(0, sec_pkg::ADDR_CONTROL, 0);
		chk("control", rv, 32'h201);
		chk("locked", locked, 0);
		presetn <= 0; repeat (3) @(posedge pclk); presetn <= 1;
		chk("frozen", frozen, 0);
		xfer(0, sec_pkg::ADDR_STATUS, 0);
		chk("status", rv, 32'h40);
	endtask : t_frozen
	task automatic close_out;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	// main sequence
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1;
		t_reset;
		t_no_prepare;
		t_bad_pw;
		t_erase_ok(2'b00, 16'h1000, 16'h0000);
		t_erase_ok(2'b11, 16'h2000, sec_pkg::ENH_PATTERN);
		t_media_err;
		t_unit_sel;
		t_frozen;
		close_out;
	end
	// watchdog
	initial begin
		repeat (60000) @(posedge pclk);
		num_errors++;
		close_out;
	end
endmodule : testbench
`default_nettype wire
